// ### include/refc_pkg.sv
// Operation
// - Cores start only in standby or active
// - Pin control off: enable bit, main code
// - Pin level enables core at main code
// - Dual level: pin picks main or low
// - Delays never apply to enable bit
// - Soft start until 0.3 V, then ramp
// - Not above 0.35 V in 1 ms: off, flag
// - Power good sets maskable flag
// - Pin pull-downs on after reset, software off
// - Ramp at coded rate, fixed frequency while ramping
// - Soft reset: cores off, defaults, bit reads 0
// - Soft reset leaves bus logic alone
// - Supply low or reset pin: all off, defaults
// - Supply and pin back: power-on, load, start
// - Flags pull interrupt low until all cleared; a masked good, cap, warn or restart flag does not pull it low
// - Restart flag after any reset start-up
// - Write 1 clears; active cap, warn, heat shutdown refuse clear
// - Heat shutdown: all off, unmaskable flag
// - Current cap 20 us: flag, status bit
// - Below 0.35 V 1 ms: off, flags, status
package refc_pkg;
   // Clock and timing figures
   localparam int CLK_PERIOD_NS  = 20;
   localparam int BOOT_US        = 1200;
   localparam int BOOT_CYC       = BOOT_US * 1000 / CLK_PERIOD_NS;
   localparam int FILTER_US      = 20;
   localparam int FILTER_CYC     = FILTER_US * 1000 / CLK_PERIOD_NS;
   localparam int SHORT_US       = 1000;
   localparam int SHORT_CYC      = SHORT_US * 1000 / CLK_PERIOD_NS;
   localparam int DELAY_STEP_US  = 1000;
   localparam int DELAY_STEP_CYC = DELAY_STEP_US * 1000 / CLK_PERIOD_NS;
   localparam int RAMP_STEP_UV   = 5000;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_MAINV   = 8'h04;
   localparam logic [7:0] ADDR_LOWV    = 8'h08;
   localparam logic [7:0] ADDR_DELAY   = 8'h0C;
   localparam logic [7:0] ADDR_RAMP    = 8'h10;
   localparam logic [7:0] ADDR_CONFIG  = 8'h14;
   localparam logic [7:0] ADDR_RESET   = 8'h15;
   localparam logic [7:0] ADDR_CFLAG   = 8'h16;
   localparam logic [7:0] ADDR_TFLAG   = 8'h1A;
   localparam logic [7:0] ADDR_CMASK   = 8'h1B;
   localparam logic [7:0] ADDR_TMASK   = 8'h1C;
   localparam logic [7:0] ADDR_CSTAT   = 8'h1D;
   localparam logic [7:0] ADDR_TSTAT   = 8'h1E;
   // Field positions
   localparam int F_EN = 0, F_PIN = 1, F_DUAL = 2, F_CHOICE = 3, F_FPWM = 4;
   localparam int F_GOOD = 0, F_SHORT = 1, F_CAP = 2;
   localparam int F_WARN = 0, F_SD = 1, F_RESTART = 2;
   // Reset values
   localparam logic [7:0] RST_CTRL  = 8'h01;
   localparam logic [7:0] RST_MAINV = 8'h64;
   localparam logic [7:0] RST_LOWV  = 8'h32;
   localparam logic [1:0] RST_PD    = 2'h3;
   // Analog and pin inputs, all from outside the clock domain
   typedef struct packed {
      logic [3:0] above_short;  // Output above 0.35 V
      logic [3:0] above_soft;   // Output above 0.3 V
      logic [3:0] good;         // Output at power-good level
      logic [3:0] cap;          // Core in peak current regulation
      logic       heat_warn;    // Die above warning level
      logic       heat_sd;      // Die above shutdown level
      logic       supply_ok;    // Analog supply above lockout
      logic [1:0] pins;         // Enable pin pair
   } refc_ana_s;
   // Ramp step period in cycles for one code step
   function automatic logic [15:0] ramp_cycles(input logic [2:0] code);
      int rate;  // Rate in 0.01 mV/us
      int cyc;
      case (code)
         3'h0:    rate = 3000;
         3'h1:    rate = 1500;
         3'h2:    rate = 1000;
         3'h3:    rate = 750;
         3'h4:    rate = 380;
         3'h5:    rate = 190;
         3'h6:    rate = 94;
         default: rate = 40;
      endcase
      cyc = RAMP_STEP_UV * 100 / (rate * CLK_PERIOD_NS);
      if (cyc < 1) cyc = 1;
      return cyc[15:0];
   endfunction
endpackage

// ### rtl/refc_top.sv
`timescale 1ns/10ps
`default_nettype none
module refc_top
   import refc_pkg::*;
#(
   parameter int BOOT_CYCLES  = BOOT_CYC,
   parameter int SHORT_CYCLES = SHORT_CYC,
   parameter int STEP_CYCLES  = DELAY_STEP_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire refc_ana_s  ana_in,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            bus_ready,
   output logic      [3:0] core_on,
   output logic      [3:0] soft_start,
   output logic      [3:0] fixed_freq_active,
   output logic      [31:0] core_vcode,
   output logic      [1:0] pin_pulldown_enable,
   output logic            irq_out_n
);
   typedef enum logic [1:0] {DS_SHUTDOWN, DS_BOOT, DS_STANDBY, DS_ACTIVE}
      refc_dev_e;
   typedef enum logic [1:0] {CS_OFF, CS_SOFT, CS_RAMP, CS_ON} refc_core_e;

   logic       rst_a, rst_n;        // Reset release synchroniser
   refc_ana_s  ana_a, ana;          // Input synchroniser stages
   refc_dev_e  dstate;              // Device state
   logic [19:0] boot_cnt;           // Power-on wait
   logic       clear;               // Registers back to defaults
   logic       soft_pulse;          // Soft reset request
   logic [7:0] ctrl  [4];           // Per-core control
   logic [7:0] mainv [4];           // Main voltage code
   logic [7:0] lowv  [4];           // Low voltage code
   logic [7:0] dly   [4];           // Rise [3:0], fall [7:4]
   logic [7:0] ramp  [4];           // Ramp code [2:0], cap code [5:3]
   logic [2:0] cflag [4];           // Good, short, cap flags
   logic [2:0] tflag;               // Warn, shutdown, restart flags
   logic [7:0] cmask;               // Good mask [3:0], cap mask [7:4]
   logic [2:0] tmask;               // Warn, -, restart masks
   logic [9:0] filt;                // Filtered good, cap, warn, sd
   logic [9:0] filt_prev;           // For rising edges
   logic [9:0] fcnt [10];           // Filter counters
   logic [3:0] pin_del;             // Pin level after delay
   logic [19:0] dcnt [4];           // Delay counters
   logic [3:0] pin_prev;            // Chosen pin last cycle
   refc_core_e cst [4];             // Core states
   logic [19:0] scnt [4];           // Low-output timer
   logic [15:0] rcnt [4];           // Ramp step timer
   logic [7:0] vcur [4];            // Present output code
   logic [3:0] want;                // Core requested on
   logic [7:0] target [4];          // Requested code
   logic [3:0] pin_sel;             // Chosen pin level
   logic       allow;               // Cores may run
   logic [3:0] short_hit;           // Short fault this cycle
   logic [9:0] hw_set;              // Flag set events
   logic [9:0] filt_in;             // Raw inputs of the filters

   // Reset release through two flops
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_a <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_a <= 1'b1;
         rst_n <= rst_a;
      end
   end

   // Two-flop synchroniser for every outside input
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ana_a <= '0;
         ana   <= '0;
      end else begin
         ana_a <= ana_in;
         ana   <= ana_a;
      end
   end

   // Device state: shutdown, power-on wait, standby, active
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dstate   <= DS_SHUTDOWN;
         boot_cnt <= '0;
      end else begin
         case (dstate)
            DS_SHUTDOWN: begin
               boot_cnt <= '0;
               if (ana.supply_ok) dstate <= DS_BOOT;
            end
            DS_BOOT: begin
               boot_cnt <= boot_cnt + 20'h0_0001;
               if (!ana.supply_ok) dstate <= DS_SHUTDOWN;
               else if (boot_cnt >= BOOT_CYCLES[19:0] - 20'h0_0001)
                  dstate <= DS_STANDBY;
            end
            DS_STANDBY, DS_ACTIVE: begin
               boot_cnt <= '0;
               if (!ana.supply_ok) dstate <= DS_SHUTDOWN;
               else if (soft_pulse) dstate <= DS_BOOT;
               else if (core_on != 4'h0) dstate <= DS_ACTIVE;
               else dstate <= DS_STANDBY;
            end
            default: dstate <= DS_SHUTDOWN;
         endcase
      end
   end

   assign clear     = (dstate == DS_SHUTDOWN) || soft_pulse;
   assign bus_ready = (dstate == DS_STANDBY) || (dstate == DS_ACTIVE);
   assign allow     = bus_ready && !tflag[F_SD] && !filt[9];

   // Register writes; defaults reload on any device reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            ctrl[i]  <= RST_CTRL;
            mainv[i] <= RST_MAINV;
            lowv[i]  <= RST_LOWV;
            dly[i]   <= 8'h00;
            ramp[i]  <= 8'h00;
         end
         cmask               <= 8'h00;
         tmask               <= 3'h0;
         pin_pulldown_enable <= RST_PD;
         soft_pulse          <= 1'b0;
      end else if (clear) begin
         for (int i = 0; i < 4; i++) begin
            ctrl[i]  <= RST_CTRL;
            mainv[i] <= RST_MAINV;
            lowv[i]  <= RST_LOWV;
            dly[i]   <= 8'h00;
            ramp[i]  <= 8'h00;
         end
         cmask               <= 8'h00;
         tmask               <= 3'h0;
         pin_pulldown_enable <= RST_PD;
         soft_pulse          <= 1'b0;
      end else begin
         soft_pulse <= 1'b0;
         if (reg_wr && bus_ready) begin
            for (int i = 0; i < 4; i++) begin
               if (reg_addr == ADDR_CTRL + 8'(i))  ctrl[i]  <= reg_wdata;
               if (reg_addr == ADDR_MAINV + 8'(i)) mainv[i] <= reg_wdata;
               if (reg_addr == ADDR_LOWV + 8'(i))  lowv[i]  <= reg_wdata;
               if (reg_addr == ADDR_DELAY + 8'(i)) dly[i]   <= reg_wdata;
               if (reg_addr == ADDR_RAMP + 8'(i))  ramp[i]  <= reg_wdata;
            end
            if (reg_addr == ADDR_CONFIG)
               pin_pulldown_enable <= reg_wdata[1:0];
            if (reg_addr == ADDR_RESET)
               soft_pulse <= reg_wdata[0];
            if (reg_addr == ADDR_CMASK) cmask <= reg_wdata;
            if (reg_addr == ADDR_TMASK) tmask <= reg_wdata[2:0];
         end
      end
   end

   // Read data one cycle later; not touched by soft reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            for (int i = 0; i < 4; i++) begin
               if (reg_addr == ADDR_CTRL + 8'(i))  reg_rdata <= ctrl[i];
               if (reg_addr == ADDR_MAINV + 8'(i)) reg_rdata <= mainv[i];
               if (reg_addr == ADDR_LOWV + 8'(i))  reg_rdata <= lowv[i];
               if (reg_addr == ADDR_DELAY + 8'(i)) reg_rdata <= dly[i];
               if (reg_addr == ADDR_RAMP + 8'(i))  reg_rdata <= ramp[i];
               if (reg_addr == ADDR_CFLAG + 8'(i))
                  reg_rdata <= {5'h00, cflag[i]};
            end
            case (reg_addr)
               ADDR_CONFIG: reg_rdata <= {6'h00, pin_pulldown_enable};
               ADDR_TFLAG:  reg_rdata <= {cflag[3] != 3'h0,
                                          cflag[2] != 3'h0,
                                          cflag[1] != 3'h0,
                                          cflag[0] != 3'h0,
                                          1'b0, tflag};
               ADDR_CMASK:  reg_rdata <= cmask;
               ADDR_TMASK:  reg_rdata <= {5'h00, tmask};
               ADDR_CSTAT:  reg_rdata <= {filt[7:4], core_on};
               ADDR_TSTAT:  reg_rdata <= {6'h00, filt[9:8]};
               default:     ;
            endcase
         end
      end
   end

   // Filter inputs gathered in one vector for indexing
   assign filt_in = {ana.heat_sd, ana.heat_warn, ana.cap, ana.good};

   // 20 us filters on good, cap, warn, shutdown inputs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         filt      <= '0;
         filt_prev <= '0;
         for (int k = 0; k < 10; k++) fcnt[k] <= '0;
      end else begin
         filt_prev <= filt;
         for (int k = 0; k < 10; k++) begin
            if (filt_in[k] == filt[k]) begin
               fcnt[k] <= '0;
            end else if (fcnt[k] >= 10'(FILTER_CYC - 1)) begin
               fcnt[k] <= '0;
               filt[k] <= ~filt[k];
            end else begin
               fcnt[k] <= fcnt[k] + 10'h001;
            end
         end
      end
   end

   // Requested state and code per core
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_sel[i] = ana.pins[ctrl[i][F_CHOICE]];
         target[i]  = mainv[i];
         if (!ctrl[i][F_PIN]) begin
            want[i] = ctrl[i][F_EN];
         end else if (!ctrl[i][F_EN]) begin
            want[i] = 1'b0;
         end else if (ctrl[i][F_DUAL]) begin
            want[i]   = 1'b1;
            target[i] = pin_sel[i] ? mainv[i] : lowv[i];
         end else begin
            want[i] = pin_del[i];
         end
      end
   end

   // Pin edge delays; only pin changes are delayed
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_del  <= '0;
         pin_prev <= '0;
         for (int i = 0; i < 4; i++) dcnt[i] <= '0;
      end else begin
         pin_prev <= pin_sel;
         for (int i = 0; i < 4; i++) begin
            if (!ctrl[i][F_PIN]) begin
               pin_del[i] <= pin_sel[i];
               dcnt[i]    <= '0;
            end else if (pin_sel[i] != pin_prev[i]) begin
               dcnt[i] <= 20'((pin_sel[i] ? dly[i][3:0] : dly[i][7:4])
                              * STEP_CYCLES);
            end else if (dcnt[i] != 20'h0_0000) begin
               dcnt[i] <= dcnt[i] - 20'h0_0001;
            end else begin
               pin_del[i] <= pin_sel[i];
            end
         end
      end
   end

   // Core sequencing: soft start, ramp, short timer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         short_hit <= '0;
         for (int i = 0; i < 4; i++) begin
            cst[i]  <= CS_OFF;
            scnt[i] <= '0;
            rcnt[i] <= '0;
            vcur[i] <= '0;
         end
      end else begin
         short_hit <= '0;
         for (int i = 0; i < 4; i++) begin
            if (clear || !allow || !want[i] || cflag[i][F_SHORT]) begin
               cst[i]  <= CS_OFF;
               scnt[i] <= '0;
               vcur[i] <= '0;
            end else begin
               // Output below 0.35 V too long ends the core
               if (ana.above_short[i]) begin
                  scnt[i] <= '0;
               end else if (scnt[i] >= 20'(SHORT_CYCLES - 1)) begin
                  short_hit[i] <= 1'b1;
               end else begin
                  scnt[i] <= scnt[i] + 20'h0_0001;
               end
               case (cst[i])
                  CS_OFF:  cst[i] <= CS_SOFT;
                  CS_SOFT: if (ana.above_soft[i]) cst[i] <= CS_RAMP;
                  CS_RAMP, CS_ON: begin
                     if (vcur[i] == target[i]) begin
                        cst[i]  <= CS_ON;
                        rcnt[i] <= '0;
                     end else begin
                        cst[i] <= CS_RAMP;
                        if (rcnt[i] >= ramp_cycles(ramp[i][2:0])
                                       - 16'h0001) begin
                           rcnt[i] <= '0;
                           vcur[i] <= (vcur[i] < target[i]) ?
                                      vcur[i] + 8'h01 : vcur[i] - 8'h01;
                        end else begin
                           rcnt[i] <= rcnt[i] + 16'h0001;
                        end
                     end
                  end
                  default: cst[i] <= CS_OFF;
               endcase
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         core_on[i]           = cst[i] != CS_OFF;
         soft_start[i]        = cst[i] == CS_SOFT;
         fixed_freq_active[i] = (cst[i] == CS_RAMP) ||
                                ctrl[i][F_FPWM];
         core_vcode[8*i +: 8] = vcur[i];
      end
   end

   // Hardware set events: good, cap, warn and shutdown rising edges
   assign hw_set = filt & ~filt_prev;

   // Sticky flags; set wins over write-1 clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) cflag[i] <= '0;
         tflag <= '0;
      end else if (clear) begin
         for (int i = 0; i < 4; i++) cflag[i] <= '0;
         tflag <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (reg_wr && bus_ready && reg_addr == ADDR_CFLAG + 8'(i)) begin
               if (reg_wdata[F_GOOD])  cflag[i][F_GOOD] <= 1'b0;
               if (reg_wdata[F_SHORT]) cflag[i][F_SHORT] <= 1'b0;
               if (reg_wdata[F_CAP] && !filt[4+i])
                  cflag[i][F_CAP] <= 1'b0;
            end
            if (hw_set[i] && core_on[i]) cflag[i][F_GOOD] <= 1'b1;
            if (short_hit[i]) cflag[i][F_SHORT] <= 1'b1;
            if (hw_set[4+i]) cflag[i][F_CAP] <= 1'b1;
         end
         if (reg_wr && bus_ready && reg_addr == ADDR_TFLAG) begin
            if (reg_wdata[F_WARN] && !filt[8]) tflag[F_WARN] <= 1'b0;
            if (reg_wdata[F_SD] && !filt[9]) tflag[F_SD] <= 1'b0;
            if (reg_wdata[F_RESTART]) tflag[F_RESTART] <= 1'b0;
         end
         if (hw_set[8]) tflag[F_WARN] <= 1'b1;
         if (hw_set[9]) tflag[F_SD] <= 1'b1;
         if (dstate == DS_BOOT && boot_cnt >= BOOT_CYCLES[19:0] - 20'h0_0001)
            tflag[F_RESTART] <= 1'b1;
      end
   end

   // Interrupt pin: OR of unmasked pending flags
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_out_n <= 1'b1;
      end else begin
         irq_out_n <= 1'b1;
         for (int i = 0; i < 4; i++) begin
            if ((cflag[i][F_GOOD] && !cmask[i]) || cflag[i][F_SHORT] ||
                (cflag[i][F_CAP] && !cmask[4+i]))
               irq_out_n <= 1'b0;
         end
         if ((tflag[F_WARN] && !tmask[F_WARN]) || tflag[F_SD] ||
             (tflag[F_RESTART] && !tmask[F_RESTART]))
            irq_out_n <= 1'b0;
      end
   end

   // Checks
   boot_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (dstate == DS_BOOT) |-> !bus_ready && core_on == 4'h0)
      else $error("core or bus live during boot");
   soft_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      soft_pulse |=> core_on == 4'h0 && dstate == DS_BOOT)
      else $error("soft reset did not stop cores");
   soft_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == ADDR_RESET) |=> reg_rdata == 8'h00)
      else $error("soft reset bit reads nonzero");
   direct_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!ctrl[0][F_PIN] && !ctrl[0][F_EN]) |=> !core_on[0])
      else $error("core on with enable bit low");
   short_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      short_hit[0] |=> cflag[0][F_SHORT] ##1 !core_on[0])
      else $error("short fault did not end core");
   heat_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tflag[F_SD] |=> core_on == 4'h0)
      else $error("core on during heat shutdown");
   irq_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(cflag[0][F_SHORT]) |=> !irq_out_n)
      else $error("interrupt pin not pulled low");
   cap_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cflag[2][F_CAP] && filt[6] && !clear) |=> cflag[2][F_CAP])
      else $error("cap flag cleared while active");
   mask_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (tflag == 3'h4 && tmask[F_RESTART] && cflag[0] == 3'h0 &&
       cflag[1] == 3'h0 && cflag[2] == 3'h0 && cflag[3] == 3'h0)
      |=> irq_out_n)
      else $error("masked flag drove interrupt");
   ramp_ffm_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cst[3] == CS_RAMP) |-> fixed_freq_active[3])
      else $error("no fixed frequency while ramping");
   pd_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clear |=> pin_pulldown_enable == RST_PD)
      else $error("pull-downs not restored");
   cov_boot_c:  cover property (@(posedge sys_clk) $rose(bus_ready));
   cov_short_c: cover property (@(posedge sys_clk) short_hit[0]);
   cov_ramp_c:  cover property (@(posedge sys_clk)
      cst[0] == CS_RAMP ##1 cst[0] == CS_ON);
   cov_dual_c:  cover property (@(posedge sys_clk)
      ctrl[1][F_DUAL] && core_on[1] && !pin_sel[1]);
endmodule
`default_nettype wire

// ### test/refc_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host side of the register port
module refc_host (
   input  wire logic       clk,
   input  wire logic [7:0] rdata,
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   output logic            wr,
   output logic            rd
);
   // Idle bus at time zero
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   // One-cycle write strobe
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read strobe, data taken one cycle later
   task automatic get(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask
endmodule
`default_nettype wire

// ### test/regulator_enable_fault_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module regulator_enable_fault_control_test;
   import refc_pkg::*;
   logic       sys_clk = 1'b0;
   logic       rstn = 1'b0;
   refc_ana_s  ana;
   logic [7:0] addr, wdata, rdata, v;
   logic       wr, rd, ready, irq_n;
   logic [3:0] on, ff;
   logic [31:0] vc;
   logic [1:0] pd;
   int         num_errors = 0;
   int         comparisons = 0;
   int         cyc = 0;
   always #10 sys_clk = ~sys_clk;
   refc_top #(.BOOT_CYCLES(50), .SHORT_CYCLES(40), .STEP_CYCLES(10)) dut_u (
      .sys_clk(sys_clk), .rstn(rstn), .ana_in(ana), .reg_addr(addr),
      .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
      .bus_ready(ready), .core_on(on), .soft_start(), .fixed_freq_active(ff),
      .core_vcode(vc), .pin_pulldown_enable(pd), .irq_out_n(irq_n));
   refc_host host_u (.clk(sys_clk), .rdata(rdata), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd));
   // Compare and count
   task automatic check(string n, logic [7:0] got, logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
         num_errors++;
      end
   endtask
   // Wait for boot to finish, bounded
   task automatic boot();
      for (int n = 0; n < 300 && ready !== 1'b1; n++) @(posedge sys_clk);
      check("ready", {7'h0, ready}, 8'h01);
   endtask
   // Defaults, restart flag, masking and clearing
   task automatic t_boot();
      check("pulldown", {6'h0, pd}, 8'h03);
      boot();
      host_u.get(ADDR_TFLAG, v);
      check("restart", v & 8'h04, 8'h04);
      check("irq", {7'h0, irq_n}, 8'h00);
      host_u.put(ADDR_TMASK, 8'h04);
      repeat (3) @(posedge sys_clk);
      check("masked", {7'h0, irq_n}, 8'h01);
      host_u.put(ADDR_TFLAG, 8'h04);
      host_u.put(ADDR_TMASK, 8'h00);
      repeat (3) @(posedge sys_clk);
      check("cleared", {7'h0, irq_n}, 8'h01);
      check("ffm", {7'h0, ff[0]}, 8'h01);
      for (int n = 0; n < 2000 && vc[7:0] !== 8'h64; n++) @(posedge sys_clk);
      check("vcode", vc[7:0], 8'h64);
      repeat (2) @(posedge sys_clk);
      check("ffmoff", {7'h0, ff[0]}, 8'h00);
      $display("boot test done");
   endtask
   // Overload on core 0, then host clears it
   task automatic t_short();
      @(posedge sys_clk);
      ana.above_short[0] <= 1'b0;
      repeat (60) @(posedge sys_clk);
      check("core0", {7'h0, on[0]}, 8'h00);
      host_u.get(ADDR_CFLAG, v);
      check("short", v & 8'h02, 8'h02);
      ana.above_short[0] <= 1'b1;
      host_u.put(ADDR_CFLAG, 8'h02);
      host_u.get(ADDR_CFLAG, v);
      check("shortclr", v & 8'h02, 8'h00);
      $display("short test done");
   endtask
   // Good and cap flags on core 0: masking, refused clear
   task automatic t_good();
      ana.good[0] <= 1'b1;
      ana.cap[0] <= 1'b1;
      repeat (1010) @(posedge sys_clk);
      host_u.get(ADDR_CFLAG, v);
      check("goodcap", v & 8'h05, 8'h05);
      check("irqgood", {7'h0, irq_n}, 8'h00);
      host_u.get(ADDR_CSTAT, v);
      check("capstat", v & 8'h11, 8'h11);
      host_u.put(ADDR_CMASK, 8'h11);
      repeat (3) @(posedge sys_clk);
      check("masked2", {7'h0, irq_n}, 8'h01);
      host_u.put(ADDR_CFLAG, 8'h05);
      host_u.get(ADDR_CFLAG, v);
      check("capkeep", v & 8'h05, 8'h04);
      ana.cap[0] <= 1'b0;
      repeat (1010) @(posedge sys_clk);
      host_u.put(ADDR_CFLAG, 8'h04);
      host_u.put(ADDR_CMASK, 8'h00);
      repeat (3) @(posedge sys_clk);
      check("capclr", {7'h0, irq_n}, 8'h01);
      $display("flag test done");
   endtask
   // Pin control holds core 1 off while pin is low
   task automatic t_pin();
      host_u.put(ADDR_CTRL + 8'h01, 8'h03);
      host_u.put(ADDR_DELAY + 8'h01, 8'h02);
      repeat (20) @(posedge sys_clk);
      check("core1", {7'h0, on[1]}, 8'h00);
      ana.pins[0] <= 1'b1;
      repeat (10) @(posedge sys_clk);
      check("rise", {7'h0, on[1]}, 8'h00);
      repeat (30) @(posedge sys_clk);
      check("pinon", {7'h0, on[1]}, 8'h01);
      host_u.put(ADDR_CTRL, 8'h00);
      repeat (2) @(posedge sys_clk);
      check("core0off", {7'h0, on[0]}, 8'h00);
      $display("pin test done");
   endtask
   // Soft reset returns defaults
   task automatic t_soft();
      host_u.put(ADDR_RESET, 8'h01);
      repeat (2) @(posedge sys_clk);
      check("allon", {4'h0, on}, 8'h00);
      boot();
      host_u.get(ADDR_RESET, v);
      check("rstbit", v, 8'h00);
      host_u.get(ADDR_CTRL + 8'h01, v);
      check("ctrl1", v, RST_CTRL);
      $display("soft reset test done");
   endtask
   // Verdict, ends the run
   task automatic summarize();
      $display("checks %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Cut a hang short
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         summarize();
      end
   end
   // Main sequence
   initial begin
      ana = '0;
      ana.supply_ok = 1'b1;
      ana.above_short = 4'hf;
      ana.above_soft = 4'hf;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      t_boot();
      t_short();
      t_good();
      t_pin();
      t_soft();
      summarize();
   end
endmodule
`default_nettype wire
